// ===== host_model.sv
// host bus master model for the register bank
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        mclk,
  input  wire logic [23:0] regRdata,
  output var logic         regWrite,
  output var logic         regRead,
  output var logic [3:0]   regAddr,
  output var logic [23:0]  regWdata
);
  initial {regWrite, regRead, regAddr, regWdata} = '0;
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    if (a == 4'h7) d[20] = 1'b0;
    if (a == 4'hB) d = 24'h90_0000;
    if (a == 4'hC) d = 24'h00_0050;
    @(posedge mclk) #1 {regWrite, regAddr, regWdata} = {1'b1, a, d};
    @(posedge mclk) #1 {regWrite, regAddr, regWdata} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [3:0] a, output logic [23:0] d);
    @(posedge mclk) #1 {regRead, regAddr} = {1'b1, a};
    @(posedge mclk) #1 {regRead, regAddr} = {1'b0, ~a};
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// ===== scan_cal_lock_monitor.sv
// port assertions for the scan and calibration register bank
`timescale 1ns/1ps
`default_nettype none
module scan_cal_lock_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [3:0]  regAddr,
  input wire logic [23:0] regWdata,
  input wire logic        conversionDone,
  input wire logic        regRvalid,
  input wire logic        waitActive,
  input wire logic [15:0] channelSelect,
  input wire logic [23:0] gainCorrectionCode,
  input wire logic        mapLocked
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence pw_write(bit open);
    regWrite && regAddr == 4'hD && ((regWdata[7:0] == 8'hA5) == open);
  endsequence
  sequence write_to(logic [3:0] a);
    regWrite && regAddr == a;
  endsequence
  a_read_answer: assert property (regRead |=> regRvalid)
    else $error("read not answered");
  a_valid_cause: assert property (regRvalid |-> $past(regRead))
    else $error("read valid without a read");
  a_lock_set: assert property (pw_write(0) |-> ##2 mapLocked)
    else $error("map not locked");
  a_unlock_set: assert property (pw_write(1) |-> ##2 !mapLocked)
    else $error("map not unlocked");
  a_locked_hold: assert property ((write_to(4'hA) and mapLocked)
    |=> $stable(gainCorrectionCode))
    else $error("locked write changed gain");
  a_gain_write: assert property ((write_to(4'hA) and !mapLocked)
    |=> gainCorrectionCode == $past(regWdata))
    else $error("gain write lost");
  a_chan_copy: assert property ((write_to(4'h7) and !mapLocked)
    |-> ##2 channelSelect == $past(regWdata[15:0], 2))
    else $error("channel select wrong");
  a_wait_cause: assert property ($rose(waitActive) |-> $past(conversionDone))
    else $error("wait without conversion end");
  a_reset_values: assert property (disable iff (1'b0) rst |=> gainCorrectionCode == 24'h80_0000 && !mapLocked)
    else $error("reset values wrong");
endmodule
bind scan_cal_lock_regs scan_cal_lock_monitor mon (
  .mclk               (mclk),
  .rst                (rst),
  .regWrite           (regWrite),
  .regRead            (regRead),
  .regAddr            (regAddr),
  .regWdata           (regWdata),
  .conversionDone     (conversionDone),
  .regRvalid          (regRvalid),
  .waitActive         (waitActive),
  .channelSelect      (channelSelect),
  .gainCorrectionCode (gainCorrectionCode),
  .mapLocked          (mapLocked)
);
`default_nettype wire

// ===== scan_cal_lock_pkg.sv
// constants for the sequencer, calibration and write-lock register bank
// Overview of operation
// - delay code 001..111 waits 8..512 modulator clock periods between conversions
// - sequencer settings bits 19..16 are not stored and read zero
// - low sixteen sequencer bits select offset, common-mode, supply, temperature, pairs, channels
// - delay value register is 24 bits, read and write, resets to zero
// - offset correction is 24-bit two's complement, resets to zero
// - gain correction is 24-bit unsigned, resets to 800000 hex
// - reserved word at 0xB resets to 0x900000; host writes only that
// - reserved byte at 0xC resets to 0x50; host writes only that
// - password 0xA5 opens all writes and holds the checksum at zero
// - any other password rejects writes except to the password register
// - while locked the checksum recomputes only while the modulator clock runs
// - password register resets to 0xA5 so the map starts writable
// - when locked a 16-bit CRC over the settings reads in the checksum register
package scan_cal_lock_pkg;
  localparam logic [3:0]  ADDR_SEQ      = 4'h7;
  localparam logic [3:0]  ADDR_DELAY    = 4'h8;
  localparam logic [3:0]  ADDR_OFFSET   = 4'h9;
  localparam logic [3:0]  ADDR_GAIN     = 4'hA;
  localparam logic [3:0]  ADDR_RSVD_B   = 4'hB;
  localparam logic [3:0]  ADDR_RSVD_C   = 4'hC;
  localparam logic [3:0]  ADDR_PASSWORD = 4'hD;
  localparam logic [3:0]  ADDR_CHECKSUM = 4'hF;
  localparam int          WAIT_MSB      = 23;
  localparam int          WAIT_LSB      = 21;
  localparam int          SEQ_RSVD_BIT  = 20;
  localparam logic [23:0] SEQ_STORE_MASK = 24'hF0_FFFF;
  localparam logic [23:0] SEQ_RESET     = 24'h00_0000;
  localparam logic [23:0] DELAY_RESET   = 24'h00_0000;
  localparam logic [23:0] OFFSET_RESET  = 24'h00_0000;
  localparam logic [23:0] GAIN_RESET    = 24'h80_0000;
  localparam logic [23:0] RSVD_B_RESET  = 24'h90_0000;
  localparam logic [7:0]  RSVD_C_RESET  = 8'h50;
  localparam logic [7:0]  UNLOCK_CODE   = 8'hA5;
  localparam logic [15:0] CRC_POLY      = 16'h8005;
  localparam logic [15:0] CRC_ZERO      = 16'h0000;
  localparam int          WAIT_BASE_LOG2 = 2;
  localparam int          CRC_BITS      = 128;
endpackage

// ===== scan_cal_lock_regs.sv
// register bank for sequencer settings, calibration codes and write lock
`timescale 1ns/1ps
`default_nettype none
module scan_cal_lock_regs (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        modulatorClockTick,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [3:0]  regAddr,
  input  wire logic [23:0] regWdata,
  input  wire logic        conversionDone,
  output logic [23:0]      regRdata,
  output logic             regRvalid,
  output logic             waitActive,
  output logic [15:0]      channelSelect,
  output logic [23:0]      delayValue,
  output logic [23:0]      offsetCorrectionCode,
  output logic [23:0]      gainCorrectionCode,
  output logic             mapLocked
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // register contents
  logic [23:0]  seqSettings_reg;
  logic [23:0]  rsvdB_reg;
  logic [7:0]   rsvdC_reg;
  logic [7:0]   password_reg;
  logic [15:0]  checksum_reg;
  // checksum shift register and bit counter
  logic [15:0]  crcWork_reg;
  logic [6:0]   crcBit_reg;
  // inter-conversion wait counter
  logic [9:0]   waitCount_reg;
  // write gating and per-register write enables
  logic         unlocked;
  logic         writeOk;
  logic         seqWrite;
  logic         delayWrite;
  logic         offsetWrite;
  logic         gainWrite;
  logic         rsvdBWrite;
  logic         rsvdCWrite;
  logic         passwordWrite;
  // read decode
  logic [23:0]  readWord;
  // checksum datapath
  logic [127:0] crcStream;
  logic [15:0]  crcNext;
  logic         crcLastBit;
  logic         feedBit;
  // wait length decode
  logic [2:0]   waitCode;
  logic [3:0]   waitShift;
  logic [9:0]   waitLength;
  logic         waitStart;

  // ------------------------------------------------------------
  // write gating
  // ------------------------------------------------------------
  assign unlocked = (password_reg == scan_cal_lock_pkg::UNLOCK_CODE);
  // the password register stays writable so that a locked map can be reopened
  assign writeOk  = regWrite &&
                    (unlocked || regAddr == scan_cal_lock_pkg::ADDR_PASSWORD);

  // ------------------------------------------------------------
  // write address decode
  // ------------------------------------------------------------
  // one enable per register; unmapped addresses enable nothing
  always_comb begin
    seqWrite      = 1'b0;
    delayWrite    = 1'b0;
    offsetWrite   = 1'b0;
    gainWrite     = 1'b0;
    rsvdBWrite    = 1'b0;
    rsvdCWrite    = 1'b0;
    passwordWrite = 1'b0;
    if (writeOk) begin
      if (regAddr == scan_cal_lock_pkg::ADDR_SEQ) begin
        seqWrite = 1'b1;
      end else if (regAddr == scan_cal_lock_pkg::ADDR_DELAY) begin
        delayWrite = 1'b1;
      end else if (regAddr == scan_cal_lock_pkg::ADDR_OFFSET) begin
        offsetWrite = 1'b1;
      end else if (regAddr == scan_cal_lock_pkg::ADDR_GAIN) begin
        gainWrite = 1'b1;
      end else if (regAddr == scan_cal_lock_pkg::ADDR_RSVD_B) begin
        rsvdBWrite = 1'b1;
      end else if (regAddr == scan_cal_lock_pkg::ADDR_RSVD_C) begin
        rsvdCWrite = 1'b1;
      end else if (regAddr == scan_cal_lock_pkg::ADDR_PASSWORD) begin
        passwordWrite = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer settings
  // ------------------------------------------------------------
  // bits 19..16 have no storage; bit 20 is kept as the host wrote it
  always_ff @(posedge mclk) begin
    if (rst) begin
      seqSettings_reg <= scan_cal_lock_pkg::SEQ_RESET;
    end else if (seqWrite) begin
      seqSettings_reg <= regWdata & scan_cal_lock_pkg::SEQ_STORE_MASK;
    end
  end

  // ------------------------------------------------------------
  // delay value
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      delayValue <= scan_cal_lock_pkg::DELAY_RESET;
    end else if (delayWrite) begin
      delayValue <= regWdata;
    end
  end

  // ------------------------------------------------------------
  // calibration codes
  // ------------------------------------------------------------
  // offset code is two's complement, stored as written
  always_ff @(posedge mclk) begin
    if (rst) begin
      offsetCorrectionCode <= scan_cal_lock_pkg::OFFSET_RESET;
    end else if (offsetWrite) begin
      offsetCorrectionCode <= regWdata;
    end
  end

  // gain code is unsigned; its reset value stands for unity gain
  always_ff @(posedge mclk) begin
    if (rst) begin
      gainCorrectionCode <= scan_cal_lock_pkg::GAIN_RESET;
    end else if (gainWrite) begin
      gainCorrectionCode <= regWdata;
    end
  end

  // ------------------------------------------------------------
  // reserved words
  // ------------------------------------------------------------
  // stored as written; the host is expected to write back the reset value only
  always_ff @(posedge mclk) begin
    if (rst) begin
      rsvdB_reg <= scan_cal_lock_pkg::RSVD_B_RESET;
    end else if (rsvdBWrite) begin
      rsvdB_reg <= regWdata;
    end
  end

  // only the low byte of the write word is stored
  always_ff @(posedge mclk) begin
    if (rst) begin
      rsvdC_reg <= scan_cal_lock_pkg::RSVD_C_RESET;
    end else if (rsvdCWrite) begin
      rsvdC_reg <= regWdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // write password
  // ------------------------------------------------------------
  // any value is taken; only the unlock code opens the map
  always_ff @(posedge mclk) begin
    if (rst) begin
      password_reg <= scan_cal_lock_pkg::UNLOCK_CODE;
    end else if (passwordWrite) begin
      password_reg <= regWdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // settings outputs
  // ------------------------------------------------------------
  // the channel selection goes out one cycle behind the stored word
  always_ff @(posedge mclk) begin
    if (rst) begin
      channelSelect <= 16'h0000;
    end else begin
      channelSelect <= seqSettings_reg[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mapLocked <= 1'b0;
    end else begin
      mapLocked <= !unlocked;
    end
  end

  // ------------------------------------------------------------
  // inter-conversion wait
  // ------------------------------------------------------------
  assign waitCode   = seqSettings_reg[scan_cal_lock_pkg::WAIT_MSB:scan_cal_lock_pkg::WAIT_LSB];
  // code n waits 2**(n+2) modulator clock periods, 8 for code 1 up to 512 for code 7
  // the shift amount is four bits wide so that codes 6 and 7 do not wrap
  assign waitShift  = {1'b0, waitCode} + 4'(scan_cal_lock_pkg::WAIT_BASE_LOG2);
  assign waitLength = 10'h001 << waitShift;
  // code 0 asks for no wait at all
  assign waitStart  = conversionDone && (waitCode != 3'b000);

  // a new conversion end restarts the count; the flag falls on the last tick
  always_ff @(posedge mclk) begin
    if (rst) begin
      waitCount_reg <= 10'h000;
      waitActive    <= 1'b0;
    end else if (waitStart) begin
      waitCount_reg <= waitLength;
      waitActive    <= 1'b1;
    end else if (waitActive && modulatorClockTick) begin
      waitCount_reg <= waitCount_reg - 10'h001;
      if (waitCount_reg == 10'h001) begin
        waitActive <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration checksum, one bit per modulator clock tick
  // ------------------------------------------------------------
  // settings, delay, offset, gain and the two reserved words, msb first
  assign crcStream  = {seqSettings_reg, delayValue, offsetCorrectionCode,
                       gainCorrectionCode, rsvdB_reg, rsvdC_reg};
  assign feedBit    = crcStream[7'(scan_cal_lock_pkg::CRC_BITS - 1) - crcBit_reg] ^
                      crcWork_reg[15];
  assign crcNext    = {crcWork_reg[14:0], 1'b0} ^
                      (feedBit ? scan_cal_lock_pkg::CRC_POLY : 16'h0000);
  assign crcLastBit = (crcBit_reg == 7'(scan_cal_lock_pkg::CRC_BITS - 1));

  // the shift register runs only while the map is locked and the modulator clock ticks
  always_ff @(posedge mclk) begin
    if (rst || unlocked) begin
      crcWork_reg <= scan_cal_lock_pkg::CRC_ZERO;
      crcBit_reg  <= 7'h00;
    end else if (modulatorClockTick) begin
      if (crcLastBit) begin
        crcWork_reg <= scan_cal_lock_pkg::CRC_ZERO;
        crcBit_reg  <= 7'h00;
      end else begin
        crcWork_reg <= crcNext;
        crcBit_reg  <= crcBit_reg + 7'h01;
      end
    end
  end

  // the result is latched after the last bit; an open map reads zero at once
  always_ff @(posedge mclk) begin
    if (rst || unlocked) begin
      checksum_reg <= scan_cal_lock_pkg::CRC_ZERO;
    end else if (modulatorClockTick && crcLastBit) begin
      checksum_reg <= crcNext;
    end
  end

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  // unstored bits and unmapped addresses read as zero
  // eight-bit registers sit in the low byte
  always_comb begin
    readWord = 24'h00_0000;
    if (regAddr == scan_cal_lock_pkg::ADDR_SEQ) begin
      readWord = seqSettings_reg;
    end else if (regAddr == scan_cal_lock_pkg::ADDR_DELAY) begin
      readWord = delayValue;
    end else if (regAddr == scan_cal_lock_pkg::ADDR_OFFSET) begin
      readWord = offsetCorrectionCode;
    end else if (regAddr == scan_cal_lock_pkg::ADDR_GAIN) begin
      readWord = gainCorrectionCode;
    end else if (regAddr == scan_cal_lock_pkg::ADDR_RSVD_B) begin
      readWord = rsvdB_reg;
    end else if (regAddr == scan_cal_lock_pkg::ADDR_RSVD_C) begin
      readWord = {16'h0000, rsvdC_reg};
    end else if (regAddr == scan_cal_lock_pkg::ADDR_PASSWORD) begin
      readWord = {16'h0000, password_reg};
    end else if (regAddr == scan_cal_lock_pkg::ADDR_CHECKSUM) begin
      readWord = {8'h00, checksum_reg};
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  // valid pulses for one cycle; read data holds until the next read
  always_ff @(posedge mclk) begin
    if (rst) begin
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdata <= 24'h00_0000;
    end else if (regRead) begin
      regRdata <= readWord;
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench for the scan and calibration register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0, rst = 1'b1, tick = 1'b0, done = 1'b0;
  wire logic regWrite, regRead, waitActive, regRvalid, mapLocked;
  wire logic [3:0] regAddr;
  wire logic [15:0] channelSelect;
  wire logic [23:0] regWdata, regRdata, delayValue, offsetCorrectionCode, gainCorrectionCode;
  logic [23:0] q, exp [16];
  int num_errors = 0, tests_run = 0, cyc = 0, cnt;
  host_model h (.mclk, .regRdata, .regWrite, .regRead, .regAddr, .regWdata);
  scan_cal_lock_regs dut (.mclk, .rst, .modulatorClockTick(tick), .regWrite, .regRead, .regAddr,
    .regWdata, .conversionDone(done), .regRdata, .regRvalid, .waitActive, .channelSelect,
    .delayValue, .offsetCorrectionCode, .gainCorrectionCode, .mapLocked);
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 20000) begin
    num_errors++;
    close_out();
  end
  task automatic check(string n, logic [23:0] s, logic [23:0] e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic read_all(string t);
    for (int a = 7; a < 16; a++) begin
      h.rd(4'(a), q);
      check($sformatf("reg %0h", a), q, exp[a]);
      check("read valid", 24'(regRvalid), 24'h00_0001);
    end
    check("channel select", 24'(channelSelect), {8'h00, exp[7][15:0]});
    check("delay out", delayValue, exp[8]);
    check("offset out", offsetCorrectionCode, exp[9]);
    check("gain out", gainCorrectionCode, exp[10]);
    check("lock flag", 24'(mapLocked), 24'(exp[13] != 24'h00_00A5));
    $display("test %s done", t);
  endtask
  // model checksum: msb first over the stored settings
  function automatic logic [23:0] crc();
    logic [127:0] m;
    logic [15:0] c;
    m = {exp[7], exp[8], exp[9], exp[10], exp[11], exp[12][7:0]};
    c = 16'h0000;
    for (int i = 127; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? 16'h8005 : 16'h0000);
    return {8'h00, c};
  endfunction
  initial begin
    exp = '{10: 24'h80_0000, 11: 24'h90_0000, 12: 24'h00_0050, 13: 24'h00_00A5, default: '0};
    void'($urandom(32'hA7B3));
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    read_all("reset");
    for (int a = 7; a < 13; a++) begin
      q = 24'($urandom);
      h.wr(4'(a), q);
      exp[a] = a == 7 ? q & 24'hE0_FFFF : a < 11 ? q : exp[a];
    end
    read_all("write");
    tick = 1'b1;
    for (int n = 0; n < 8; n++) begin
      exp[7][23:21] = 3'(n);
      h.wr(4'h7, exp[7]);
      @(posedge mclk) #1 done = 1'b1;
      @(posedge mclk) #1 done = 1'b0;
      cnt = int'(waitActive === 1'b1);
      repeat (600) begin
        @(posedge mclk);
        #1 if (waitActive === 1'b1) cnt++;
      end
      check("wait ticks", 24'(cnt), n > 0 ? 24'(4 << n) : 24'h00_0000);
    end
    $display("test wait done");
    h.wr(4'hD, 24'h00_003C);
    exp[13] = 24'h00_003C;
    for (int a = 7; a < 13; a++) h.wr(4'(a), 24'($urandom));
    repeat (400) @(posedge mclk);
    exp[15] = crc();
    read_all("lock");
    h.wr(4'hD, 24'h00_00A5);
    {exp[13], exp[15]} = {24'h00_00A5, 24'h00_0000};
    read_all("unlock");
    tick = 1'b0;
    h.wr(4'hD, 24'h00_0011);
    repeat (400) @(posedge mclk);
    h.rd(4'hF, q);
    check("stopped checksum", q, 24'h00_0000);
    $display("test stopped clock done");
    close_out();
  end
endmodule
`default_nettype wire
